// ### rtl/epc_eprom_program_control.sv
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "epc_regs.svh"
module epc_eprom_program_control
   import epc_pkg::*;
#(
   // Array geometry; the capture record fixes both
   parameter int ADDR_W = 14,
   parameter int DATA_W = 8
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // CPU side EPROM bus
   input wire logic cpu_wr_i,
   input wire logic [ADDR_W-1:0] cpu_addr_i,
   input wire logic [DATA_W-1:0] cpu_wdata_i,
   output logic cpu_read_enable_o,
   // Mode straps
   input wire logic irq_at_test_level_i,
   input wire logic capture_input_pin_i,
   input wire logic function_select_hi_i,
   input wire logic function_select_mid_i,
   input wire logic function_select_lo_i,
   // EPROM array and indicators
   output logic program_voltage_enable_o,
   output logic [ADDR_W-1:0] eprom_addr_o,
   output logic [DATA_W-1:0] eprom_data_o,
   output logic boot_mode_o,
   output logic boot_rom_sel_o,
   output logic programming_indicator_out_o,
   output logic verify_indicator_out_o
);
   // Control register and its next value
   logic latch_ff;
   logic volt_ff;
   logic nxt_latch;
   logic nxt_volt;

   // Capture of the byte under programming
   logic armed_ff;
   logic captured_ff;
   epc_capture_t capt_ff;

   // Mode taken after reset
   logic rst_d_ff;
   logic boot_ff;
   epc_func_t func_ff;
   epc_func_t nxt_func;

   // Bus answer
   logic ack_ff;
   logic [31:0] rdata_ff;

   // The capture record holds a 14-bit address and an 8-bit byte
   if (ADDR_W != 14 || DATA_W != 8)
   begin : g_width_check
      $error("array widths do not fit the capture record");
   end

   // Control word as read back, reserved bits as zero
   function automatic logic [31:0] ctrl_word(input logic latch,
      input logic volt);
      logic [31:0] word;
      word = 32'h0000_0000;
      word[`EPC_CTRL_LATCH] = latch;
      word[`EPC_CTRL_VOLT] = volt;
      return word;
   endfunction

   // Boot ROM window decode
   function automatic logic rom_hit(input logic [ADDR_W-1:0] a);
      return a >= `EPC_BOOT_ROM_LO && a <= `EPC_BOOT_ROM_HI;
   endfunction

   // A request is taken once; the ack cycle blocks a second take
   wire logic req = cyc_i && stb_i && !ack_ff;
   wire logic wr_ctrl = req && we_i && sel_i[0] &&
      (adr_i == `EPC_ADDR_CTRL);
   wire logic w_latch = dat_i[`EPC_CTRL_LATCH];
   wire logic w_volt = dat_i[`EPC_CTRL_VOLT];
   wire logic [2:0] fsel = {function_select_hi_i, function_select_mid_i,
      function_select_lo_i};
   wire logic in_rom = rom_hit(cpu_addr_i);
   wire logic boot_strap = irq_at_test_level_i && capture_input_pin_i;
   // Only a write outside the boot ROM is a byte to program
   wire logic take_byte = armed_ff && cpu_wr_i && !in_rom;
   wire logic [31:0] status_word = {24'h0, func_ff, armed_ff, captured_ff,
      volt_ff, boot_ff};
   wire logic [31:0] capt_word = {10'h0, capt_ff};
   // Eprom_write_control/verify lights the verify lamp until a byte is under way
   wire logic verify_phase = func_ff == EPC_FN_VERIFY_ONLY ||
      (func_ff == EPC_FN_EPROM_WRITE_CONTROL_VERIFY && !latch_ff && !captured_ff);

   // Voltage may rise only on a later write than the one setting latch
   always_comb
   begin
      nxt_latch = latch_ff;
      nxt_volt = volt_ff;
      if (wr_ctrl)
      begin
         nxt_latch = w_latch;
         nxt_volt = w_volt && latch_ff && !(w_latch && !latch_ff);
         if (w_latch && w_volt && !latch_ff)
            nxt_volt = 1'b0;
         // Voltage cannot outlive a latch clear
         if (!w_latch)
            nxt_volt = 1'b0;
      end
   end

   // One-hot function code from the three select pins
   always_comb
   begin
      case (fsel)
         3'b000: nxt_func = EPC_FN_EPROM_WRITE_CONTROL_VERIFY;
         3'b001: nxt_func = EPC_FN_VERIFY_ONLY;
         3'b010: nxt_func = EPC_FN_LOAD_RAM;
         default: nxt_func = EPC_FN_NONE;
      endcase
   end

   // Mode caught on the first clock after reset release
   always_ff @(posedge clk_i)
   begin
      rst_d_ff <= rst_i;
      if (rst_i)
      begin
         boot_ff <= 1'b0;
         func_ff <= EPC_FN_NONE;
      end
      else if (rst_d_ff)
      begin
         boot_ff <= boot_strap;
         func_ff <= nxt_func;
      end
   end

   // Control register; reset clears both bits
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         latch_ff <= 1'b0;
         volt_ff <= 1'b0;
      end
      else
      begin
         latch_ff <= nxt_latch;
         volt_ff <= nxt_volt;
      end
   end

   // Arm on latch set, capture first EPROM write after that
   always_ff @(posedge clk_i)
   begin
      if (rst_i || !latch_ff)
      begin
         armed_ff <= 1'b0;
         captured_ff <= 1'b0;
         capt_ff <= '0;
      end
      // A clock of delay keeps the latch-setting cycle out of the capture
      else if (!armed_ff && !captured_ff)
         armed_ff <= 1'b1;
      else if (take_byte)
      begin
         armed_ff <= 1'b0;
         captured_ff <= 1'b1;
         capt_ff <= '{addr: cpu_addr_i, data: cpu_wdata_i};
      end
   end

   // Answer registered one cycle after the take
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         ack_ff <= req;
         case (adr_i)
            `EPC_ADDR_CTRL:
               rdata_ff <= ctrl_word(latch_ff, volt_ff);
            `EPC_ADDR_STATUS:
               rdata_ff <= status_word;
            `EPC_ADDR_CAPT:
               rdata_ff <= capt_word;
            // Unmapped offsets read as zero
            default:
               rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   assign ack_o = ack_ff;
   assign dat_o = rdata_ff;
   // Latch clear reopens the normal read path
   assign cpu_read_enable_o = !latch_ff;
   assign program_voltage_enable_o = volt_ff;
   // Latched address drives the array while programming
   assign eprom_addr_o = latch_ff ? capt_ff.addr : cpu_addr_i;
   assign eprom_data_o = capt_ff.data;
   assign boot_mode_o = boot_ff;
   assign boot_rom_sel_o = boot_ff && in_rom;
   // In boot mode the indicators follow programming voltage and verify selection
   assign programming_indicator_out_o = boot_ff && volt_ff;
   assign verify_indicator_out_o = boot_ff && verify_phase;
endmodule // epc_eprom_program_control
`default_nettype wire

// ### rtl/epc_regs.svh
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH
`define EPC_ADDR_CTRL 4'h0
`define EPC_ADDR_STATUS 4'h4
`define EPC_ADDR_CAPT 4'h8
`define EPC_CTRL_LATCH 2
`define EPC_CTRL_VOLT 0
`define EPC_CTRL_RESET 8'h00
`define EPC_BOOT_ROM_LO 14'h3F00
`define EPC_BOOT_ROM_HI 14'h3FEF
`endif

// ### rtl/epc_pkg.sv
package epc_pkg;
   typedef enum logic [3:0]
   {
      EPC_FN_EPROM_WRITE_CONTROL_VERIFY = 4'b0001,
      EPC_FN_VERIFY_ONLY = 4'b0010,
      EPC_FN_LOAD_RAM = 4'b0100,
      EPC_FN_NONE = 4'b1000
   } epc_func_t;
   typedef struct packed
   {
      logic [13:0] addr;
      logic [7:0] data;
   } epc_capture_t;
endpackage

// ### bench/epc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module epc_chk (
   // Watched ports
   input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cpu_wr_i,
   input wire logic cpu_read_enable_o, program_voltage_enable_o,
   input wire logic boot_mode_o, programming_indicator_out_o,
   input wire logic boot_rom_sel_o,
   input wire logic [3:0] adr_i, sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [13:0] cpu_addr_i,
   input wire logic [7:0] cpu_wdata_i, eprom_data_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic wr_c = cyc_i && stb_i && we_i && !ack_o && adr_i == 4'h0
      && sel_i[0];
   a_latch_set: assert property (wr_c && dat_i[2] |=> !cpu_read_enable_o)
      else $error("latch set kept reads");
   a_latch_clr: assert property (wr_c && !dat_i[2] |=> cpu_read_enable_o)
      else $error("latch clear blocked reads");
   a_volt_on: assert property (wr_c && dat_i[2] && dat_i[0]
      && !cpu_read_enable_o |=> program_voltage_enable_o)
      else $error("voltage not applied");
   a_volt_need: assert property ($rose(program_voltage_enable_o)
      |-> !$past(cpu_read_enable_o))
      else $error("voltage without latch");
   a_both_one: assert property (wr_c && dat_i[0] && cpu_read_enable_o
      |=> !program_voltage_enable_o)
      else $error("voltage set with latch");
   a_eprom_write_control_led: assert property (programming_indicator_out_o ==
      (boot_mode_o && program_voltage_enable_o))
      else $error("program lamp wrong");
   a_capt_data: assert property (!cpu_read_enable_o && cpu_wr_i
      && !$past(cpu_read_enable_o)
      && !(cpu_addr_i inside {[14'h3F00:14'h3FEF]})
      |=> eprom_data_o == $past(cpu_wdata_i))
      else $error("byte not captured");
   a_rom_sel: assert property (cpu_read_enable_o |-> boot_rom_sel_o ==
      (boot_mode_o && cpu_addr_i inside {[14'h3F00:14'h3FEF]}))
      else $error("boot rom select wrong");
endmodule // epc_chk
bind epc_eprom_program_control epc_chk u_chk (.*);
`default_nettype wire

// ### bench/epc_src.sv
`timescale 1ns/1ps
`default_nettype none
module epc_src (
   input wire logic clk_i, rst_i, go_i,
   input wire logic [21:0] src_i,
   output logic wr_o,
   output logic [21:0] bus_o
);
   // One write per request, then the bus shows the inverse
   always_ff @(posedge clk_i)
   begin
      wr_o <= go_i;
      bus_o <= go_i ? src_i : (rst_i ? 22'h0 : ~src_i);
   end
endmodule // epc_src
`default_nettype wire

// ### bench/epc_eprom_program_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module epc_eprom_program_control_bench;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, go = 0;
   logic irq_at_test_level_i = 1, capture_input_pin_i = 1;
   logic function_select_hi_i = 0, function_select_mid_i = 0;
   logic function_select_lo_i = 0, cpu_wr_i, ack_o, cpu_read_enable_o;
   logic program_voltage_enable_o, boot_mode_o, boot_rom_sel_o;
   logic programming_indicator_out_o, verify_indicator_out_o;
   logic [3:0] adr_i = 4'h0, sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0, dat_o, q;
   logic [21:0] src = 22'h0, bus;
   logic [13:0] eprom_addr_o;
   logic [7:0] eprom_data_o;
   int bad_count = 0, n_tests = 0, cyc_n = 0;
   wire logic [13:0] cpu_addr_i = bus[21:8];
   wire logic [7:0] cpu_wdata_i = bus[7:0];
   epc_eprom_program_control dut (.*);
   epc_src u_src (.clk_i, .rst_i, .go_i(go), .src_i(src), .wr_o(cpu_wr_i),
      .bus_o(bus));
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (++cyc_n == 5000)
      begin
         bad_count++;
         end_sim();
      end
   task automatic end_sim();
      $display("tests %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(string s, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("Error %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rst();
      rst_i <= 1;
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic wb(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge clk_i) {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <=
         {2'h3, w, a, 4'hF, d};
      do @(posedge clk_i); while (ack_o !== 1'h1);
      q = dat_o;
      {cyc_i, stb_i} <= 2'h0;
   endtask
   task automatic feed(logic [21:0] v);
      src <= v;
      go <= 1'h1;
      @(posedge clk_i) go <= 1'h0;
      @(posedge clk_i);
   endtask
   task automatic t_user();
      capture_input_pin_i <= 1'h0;
      function_select_hi_i <= 1'h1;
      rst();
      cmp("user", 1'h0, boot_mode_o);
      wb(1'h0, 4'h4, 32'h0);
      cmp("none", 32'h8, q[7:4]);
      cmp("vled off", 1'h0, verify_indicator_out_o);
      feed({14'h3F00, 8'h00});
      cmp("rom user", 1'h0, boot_rom_sel_o);
      capture_input_pin_i <= 1'h1;
      irq_at_test_level_i <= 1'h0;
      rst();
      cmp("irq low", 1'h0, boot_mode_o);
      irq_at_test_level_i <= 1'h1;
      function_select_hi_i <= 1'h0;
   endtask
   task automatic t_modes();
      for (int i = 2; i >= 0; i--)
      begin
         function_select_mid_i <= (i == 2);
         function_select_lo_i <= (i == 1);
         rst();
         cmp("boot", 1'h1, boot_mode_o);
         wb(1'h0, 4'h4, 32'h0);
         cmp("func", 32'h1 << i, q[7:4]);
         cmp("vled", i != 2, verify_indicator_out_o);
      end
   endtask
   task automatic t_rom();
      feed({14'h3F00, 8'h00});
      cmp("rom lo", 1'h1, boot_rom_sel_o);
      feed({14'h3FEF, 8'h00});
      cmp("rom top", 1'h1, boot_rom_sel_o);
      feed({14'h3FF0, 8'h00});
      cmp("rom hi", 1'h0, boot_rom_sel_o);
      feed({14'h3EFF, 8'h00});
      cmp("rom below", 1'h0, boot_rom_sel_o);
   endtask
   task automatic t_eprom_write_control();
      wb(1'h1, 4'h0, 32'h1);
      cmp("nolatch", 1'h0, program_voltage_enable_o);
      wb(1'h1, 4'h0, 32'h5);
      cmp("both", 1'h0, program_voltage_enable_o);
      wb(1'h1, 4'h0, 32'h4);
      cmp("rd off", 1'h0, cpu_read_enable_o);
      feed({14'h0123, 8'hA5});
      wb(1'h1, 4'h0, 32'h5);
      cmp("volt", 1'h1, program_voltage_enable_o);
      cmp("pled", 1'h1, programming_indicator_out_o);
      cmp("addr", 14'h0123, eprom_addr_o);
      cmp("data", 8'hA5, eprom_data_o);
      wb(1'h0, 4'h8, 32'h0);
      cmp("capt", 32'h0123A5, q);
      wb(1'h1, 4'h0, 32'h4);
      cmp("volt off", 1'h0, program_voltage_enable_o);
      cmp("pled off", 1'h0, programming_indicator_out_o);
      wb(1'h1, 4'h0, 32'h0);
      cmp("rd on", 1'h1, cpu_read_enable_o);
      wb(1'h0, 4'hC, 32'h0);
      cmp("unmapped", 32'h0, q);
   endtask
   initial
   begin
      t_user();
      t_modes();
      t_rom();
      t_eprom_write_control();
      end_sim();
   end
endmodule // epc_eprom_program_control_bench
`default_nettype wire
